// *** design/mmd_map.vh ***
/*
 * constants for the multiply and move decode block: opcode patterns,
 * sub-opcode field values and special register numbers.
 * assumes inclusion by bare name from design files.
 */
`ifndef MMD_MAP_VH
`define MMD_MAP_VH

`define MMD_REG_SP 4'hd
`define MMD_REG_PC 4'hf

// 16-bit opcode patterns
`define MMD_OP16_MOVI_MASK 16'hf800
`define MMD_OP16_MOVI_VAL 16'h2000
`define MMD_OP16_MOVR_MASK 16'hff00
`define MMD_OP16_MOVR_VAL 16'h4600
`define MMD_OP16_MOVF_MASK 16'hffc0
`define MMD_OP16_MOVF_VAL 16'h0000

// 32-bit first halfword patterns, then the register move second halfword pattern
`define MMD_OP32_MAC_MASK 16'hfff0
`define MMD_OP32_MAC_VAL 16'hfb00
`define MMD_OP32_MOVI_MASK 16'hfbef
`define MMD_OP32_MOVI_VAL 16'hf04f
`define MMD_OP32_WIDE_MASK 16'hfbf0
`define MMD_OP32_WIDE_VAL 16'hf240
`define MMD_OP32_TOP_VAL 16'hf2c0
`define MMD_OP32_MOVR_MASK 16'hffef
`define MMD_OP32_MOVR_VAL 16'hea4f
`define MMD_OP32_MOVR_LO_MASK 16'hf0f0
`define MMD_OP32_MOVR_LO_VAL 16'h0000

// second halfword fields of the multiply pair
`define MMD_MAC_SUB_ZERO 4'h0
`define MMD_MAC_SUB_ONE 4'h1

`endif

// *** design/mmd_imm_expand.v ***
/*
 * modified_immediate_expand: 12-bit compact immediate to 32-bit value
 * and carry. assumes a purely combinational caller.
 */
`timescale 1ns/10ps
module mmd_imm_expand
(
    // encoded immediate and current carry
    input wire [11:0] imm12_i,
    input wire carry_in_i,
    // expanded value
    output reg [31:0] imm32_o,
    output reg carry_o
);

    reg [7:0] byte_v;
    reg [31:0] unrot;
    reg [4:0] rot;

    always @*
    begin
        byte_v = imm12_i[7:0];
        unrot = {24'h000000, 1'b1, imm12_i[6:0]};
        rot = imm12_i[11:7];
        imm32_o = 32'h00000000;
        carry_o = carry_in_i;
        if (imm12_i[11:10] == 2'b00)
        begin
            case (imm12_i[9:8])
                2'b00: imm32_o = {24'h000000, byte_v};
                2'b01: imm32_o = {8'h00, byte_v, 8'h00, byte_v};
                2'b10: imm32_o = {byte_v, 8'h00, byte_v, 8'h00};
                default: imm32_o = {byte_v, byte_v, byte_v, byte_v};
            endcase
        end
        else
        begin
            // rotate right; amount is at least 8 so the carry is always bit 31
            imm32_o = (unrot >> rot) | (unrot << (6'd32 - {1'b0, rot}));
            carry_o = imm32_o[31];
        end
    end

endmodule

// *** design/mmd_decode.v ***
/*
 * decode and execute for the multiply-accumulate/subtract and move group.
 * assumes the core supplies one instruction per valid cycle, reads the
 * register file combinationally on the index outputs, evaluates the
 * condition and conditional block position itself. results are registered.
 */
// Our own choices: the strobed register port and the register addresses.
// Summary of operation
// - accumulate: low 32 bits of product plus addend
// - accumulate fields from both halfwords decoded
// - subtract: addend minus product, low 32 bits
// - subtract: same fields, bits 7..4 one
// - subtract with sp or pc flagged unpredictable
// - narrow immediate move: zero-extend, flags outside block
// - wide immediate move: expanded constant, S flags
// - 16-bit wide immediate, zero-extended, no flags
// - immediate move flags: N, Z; C from the wide expansion, kept on narrow; V kept
// - narrow register move: D:Rd index, no flags
// - narrow move to pc mid-block unpredictable
// - flag move always sets flags; block unpredictable
// - wide register move sp/pc combinations unpredictable
// - narrow register move into pc is a branch
// - shifted moves belong to the shift decoder
// - top halfword write keeps low half
// - top immediate order imm4:i:imm3:imm8; sp/pc unpredictable
`timescale 1ns/10ps
`include "mmd_map.vh"
module mmd_decode
(
    // clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // instruction in
    input wire instr_valid_i,
    input wire [31:0] instr_i,
    input wire is_32bit_i,
    input wire cond_pass_i,
    input wire in_cond_block_i,
    input wire last_in_block_i,
    // register read ports and current flags
    output reg [3:0] rd_idx_a_o,
    output reg [3:0] rd_idx_b_o,
    output reg [3:0] rd_idx_c_o,
    input wire [31:0] rd_data_a_i,
    input wire [31:0] rd_data_b_i,
    input wire [31:0] rd_data_c_i,
    input wire [3:0] flags_i,
    // writeback
    output reg wr_en_o,
    output reg [3:0] wr_idx_o,
    output reg [31:0] wr_data_o,
    output reg flags_wr_o,
    output reg [3:0] flags_o,
    output reg branch_o,
    output reg [31:0] branch_addr_o,
    // decode status
    output reg claimed_o,
    output reg unpredictable_o
);

    localparam OP_NONE = 3'd0;
    localparam OP_MAC = 3'd1;
    localparam OP_MSUB = 3'd2;
    localparam OP_MOVE = 3'd3;
    localparam OP_TOP = 3'd4;

    wire [15:0] hw1 = instr_i[31:16];
    wire [15:0] hw2 = instr_i[15:0];
    wire [15:0] n16 = instr_i[15:0];
    wire flag_c = flags_i[1];
    wire flag_v = flags_i[0];

    wire [31:0] exp_imm;
    wire exp_carry;

    mmd_imm_expand u_expand
    (
        .imm12_i({hw1[10], hw2[14:12], hw2[7:0]}),
        .carry_in_i(flag_c),
        .imm32_o(exp_imm),
        .carry_o(exp_carry)
    );

    reg [2:0] op;
    reg [3:0] dest;
    reg [31:0] imm_val;
    reg set_flags;
    reg imm_carry;
    reg use_imm_c;
    reg bad;
    reg [63:0] prod;
    reg [31:0] result;

    function is_sp_pc;
        input [3:0] r;
        begin
            is_sp_pc = (r == `MMD_REG_SP) || (r == `MMD_REG_PC);
        end
    endfunction

    always @*
    begin
        op = OP_NONE;
        dest = 4'h0;
        imm_val = 32'h00000000;
        set_flags = 1'b0;
        imm_carry = flag_c;
        use_imm_c = 1'b0;
        bad = 1'b0;
        rd_idx_a_o = 4'h0;
        rd_idx_b_o = 4'h0;
        rd_idx_c_o = 4'h0;
        if (is_32bit_i)
        begin
            if ((hw1 & `MMD_OP32_MAC_MASK) == `MMD_OP32_MAC_VAL &&
                (hw2[7:4] == `MMD_MAC_SUB_ZERO || hw2[7:4] == `MMD_MAC_SUB_ONE))
            begin
                op = (hw2[7:4] == `MMD_MAC_SUB_ONE) ? OP_MSUB : OP_MAC;
                rd_idx_a_o = hw1[3:0];
                rd_idx_b_o = hw2[3:0];
                rd_idx_c_o = hw2[15:12];
                dest = hw2[11:8];
                if (op == OP_MSUB)
                begin
                    bad = is_sp_pc(hw2[11:8]) || is_sp_pc(hw1[3:0]) ||
                          is_sp_pc(hw2[3:0]) || is_sp_pc(hw2[15:12]);
                end
            end
            else if ((hw1 & `MMD_OP32_MOVI_MASK) == `MMD_OP32_MOVI_VAL && !hw2[15])
            begin
                op = OP_MOVE;
                dest = hw2[11:8];
                imm_val = exp_imm;
                imm_carry = exp_carry;
                use_imm_c = 1'b1;
                set_flags = hw1[4];
                bad = is_sp_pc(dest);
            end
            else if (((hw1 & `MMD_OP32_WIDE_MASK) == `MMD_OP32_WIDE_VAL ||
                      (hw1 & `MMD_OP32_WIDE_MASK) == `MMD_OP32_TOP_VAL) && !hw2[15])
            begin
                op = (hw1[7]) ? OP_TOP : OP_MOVE;
                dest = hw2[11:8];
                rd_idx_a_o = hw2[11:8];
                imm_val = {16'h0000, hw1[3:0], hw1[10], hw2[14:12], hw2[7:0]};
                bad = is_sp_pc(dest);
            end
            else if ((hw1 & `MMD_OP32_MOVR_MASK) == `MMD_OP32_MOVR_VAL &&
                     (hw2 & `MMD_OP32_MOVR_LO_MASK) == `MMD_OP32_MOVR_LO_VAL)
            begin
                // nonzero shift fields fall to the shift decoder
                op = OP_MOVE;
                dest = hw2[11:8];
                rd_idx_a_o = hw2[3:0];
                set_flags = hw1[4];
                if (hw1[4])
                begin
                    bad = is_sp_pc(dest) || is_sp_pc(hw2[3:0]);
                end
                else
                begin
                    bad = dest == `MMD_REG_PC || hw2[3:0] == `MMD_REG_PC ||
                          (dest == `MMD_REG_SP && hw2[3:0] == `MMD_REG_SP);
                end
            end
        end
        else
        begin
            if ((n16 & `MMD_OP16_MOVI_MASK) == `MMD_OP16_MOVI_VAL)
            begin
                op = OP_MOVE;
                dest = {1'b0, n16[10:8]};
                imm_val = {24'h000000, n16[7:0]};
                set_flags = !in_cond_block_i;
                use_imm_c = 1'b1;
            end
            else if ((n16 & `MMD_OP16_MOVR_MASK) == `MMD_OP16_MOVR_VAL)
            begin
                op = OP_MOVE;
                dest = {n16[7], n16[2:0]};
                rd_idx_a_o = n16[6:3];
                bad = dest == `MMD_REG_PC && in_cond_block_i && !last_in_block_i;
            end
            else if ((n16 & `MMD_OP16_MOVF_MASK) == `MMD_OP16_MOVF_VAL)
            begin
                op = OP_MOVE;
                dest = {1'b0, n16[2:0]};
                rd_idx_a_o = {1'b0, n16[5:3]};
                set_flags = 1'b1;
                bad = in_cond_block_i;
            end
        end
    end

    always @*
    begin
        prod = rd_data_a_i * rd_data_b_i;
        case (op)
            OP_MAC: result = rd_data_c_i + prod[31:0];
            OP_MSUB: result = rd_data_c_i - prod[31:0];
            OP_TOP: result = {imm_val[15:0], rd_data_a_i[15:0]};
            OP_MOVE: result = (use_imm_c || (is_32bit_i && hw1[15:11] == 5'b11110)) ? imm_val : rd_data_a_i;
            default: result = 32'h00000000;
        endcase
    end

    wire fire = instr_valid_i && op != OP_NONE && cond_pass_i;
    wire is_reg_move = op == OP_MOVE && !(use_imm_c || (is_32bit_i && hw1[15:11] == 5'b11110));
    wire to_pc = is_reg_move && !is_32bit_i && dest == `MMD_REG_PC;

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wr_en_o <= 1'b0;
            wr_idx_o <= 4'h0;
            wr_data_o <= 32'h00000000;
            flags_wr_o <= 1'b0;
            flags_o <= 4'h0;
            branch_o <= 1'b0;
            branch_addr_o <= 32'h00000000;
            claimed_o <= 1'b0;
            unpredictable_o <= 1'b0;
        end
        else
        begin
            claimed_o <= instr_valid_i && op != OP_NONE;
            unpredictable_o <= instr_valid_i && op != OP_NONE && bad;
            // a narrow register move to pc goes through the branch path, not the register file
            wr_en_o <= fire && !to_pc;
            wr_idx_o <= dest;
            wr_data_o <= result;
            branch_o <= fire && to_pc;
            branch_addr_o <= result;
            flags_wr_o <= fire && set_flags && (op == OP_MOVE);
            if (use_imm_c || !is_reg_move)
            begin
                flags_o <= {result[31], result == 32'h00000000, imm_carry, flag_v};
            end
            else
            begin
                flags_o <= {result[31], result == 32'h00000000, flag_c, flag_v};
            end
        end
    end

endmodule

// *** tb/mmd_decode_asserts.sv ***
/*
 * concurrent checks on the ports of the multiply and move decoder.
 * assumes results registered one cycle after the taking edge.
 */
`timescale 1ns/10ps
module mmd_decode_asserts
(
    // clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // instruction in
    input wire instr_valid_i,
    input wire [31:0] instr_i,
    input wire is_32bit_i,
    input wire cond_pass_i,
    input wire in_cond_block_i,
    input wire last_in_block_i,
    // register reads and flags
    input wire [3:0] rd_idx_a_o,
    input wire [3:0] rd_idx_b_o,
    input wire [3:0] rd_idx_c_o,
    input wire [31:0] rd_data_a_i,
    input wire [31:0] rd_data_b_i,
    input wire [31:0] rd_data_c_i,
    input wire [3:0] flags_i,
    // writeback and status
    input wire wr_en_o,
    input wire [3:0] wr_idx_o,
    input wire [31:0] wr_data_o,
    input wire flags_wr_o,
    input wire [3:0] flags_o,
    input wire branch_o,
    input wire [31:0] branch_addr_o,
    input wire claimed_o,
    input wire unpredictable_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    function automatic logic spc(input logic [3:0] x);
        spc = (x == 4'hd) || (x == 4'hf);
    endfunction
    wire tk = instr_valid_i && cond_pass_i;
    wire mul = tk && is_32bit_i && instr_i[31:20] == 12'hfb0;
    wire mac = mul && instr_i[7:4] == 4'h0;
    wire msub = mul && instr_i[7:4] == 4'h1;
    wire mi16 = tk && !is_32bit_i && instr_i[15:11] == 5'h04;
    wire mvw = tk && is_32bit_i && (instr_i[31:16] & 16'hfbf0) == 16'hf240;
    wire mvt = tk && is_32bit_i && (instr_i[31:16] & 16'hfbf0) == 16'hf2c0;
    wire pcm = tk && !is_32bit_i && instr_i[15:8] == 8'h46 && instr_i[7] && instr_i[2:0] == 3'h7;
    wire [15:0] i16 = {instr_i[19:16], instr_i[26], instr_i[14:12], instr_i[7:0]};
    AST_COND_FAIL: assert property (instr_valid_i && !cond_pass_i |=> !wr_en_o && !flags_wr_o && !branch_o)
        else $error("write despite failed condition");
    AST_MAC_IDX: assert property (mac |-> rd_idx_a_o == instr_i[19:16] && rd_idx_b_o == instr_i[3:0]
        && rd_idx_c_o == instr_i[15:12]) else $error("accumulate read indices wrong");
    AST_MAC: assert property (mac |=> wr_en_o && wr_idx_o == $past(instr_i[11:8])
        && wr_data_o == $past(rd_data_a_i) * $past(rd_data_b_i) + $past(rd_data_c_i)) else $error("accumulate wrong");
    AST_MSUB: assert property (msub |=> wr_en_o && wr_idx_o == $past(instr_i[11:8])
        && wr_data_o == $past(rd_data_c_i) - $past(rd_data_a_i) * $past(rd_data_b_i)) else $error("subtract wrong");
    AST_MSUB_UNP: assert property (msub && (spc(instr_i[19:16]) || spc(instr_i[15:12]) || spc(instr_i[11:8])
        || spc(instr_i[3:0])) |=> unpredictable_o) else $error("subtract sp or pc not flagged");
    AST_MI16: assert property (mi16 |=> wr_en_o && wr_data_o == {24'h0, $past(instr_i[7:0])}
        && flags_wr_o == !$past(in_cond_block_i)) else $error("narrow immediate move wrong");
    AST_MI16_FLAGS: assert property (mi16 && !in_cond_block_i |=> flags_o == {1'b0,
        $past(instr_i[7:0]) == 8'h0, $past(flags_i[1]), $past(flags_i[0])}) else $error("narrow move flags wrong");
    AST_WIDE: assert property (mvw |=> wr_en_o && wr_data_o == {16'h0, $past(i16)} && !flags_wr_o)
        else $error("wide immediate move wrong");
    AST_TOP: assert property (mvt |=> wr_data_o == {$past(i16), $past(rd_data_a_i[15:0])} && !flags_wr_o)
        else $error("top halfword move wrong");
    AST_PC: assert property (pcm && (!in_cond_block_i || last_in_block_i) |=> branch_o && !wr_en_o
        && branch_addr_o == $past(rd_data_a_i)) else $error("move to pc not a branch");
    AST_PC_UNP: assert property (pcm && in_cond_block_i && !last_in_block_i |=> unpredictable_o)
        else $error("mid-block move to pc not flagged");
    cover property (branch_o);
    cover property (flags_wr_o && flags_o[2]);
    cover property (unpredictable_o && wr_en_o);
endmodule
bind mmd_decode mmd_decode_asserts u_chk (.mclk_i, .rst_n_i, .instr_valid_i, .instr_i, .is_32bit_i, .cond_pass_i,
    .in_cond_block_i, .last_in_block_i, .rd_idx_a_o, .rd_idx_b_o, .rd_idx_c_o, .rd_data_a_i, .rd_data_b_i,
    .rd_data_c_i, .flags_i, .wr_en_o, .wr_idx_o, .wr_data_o, .flags_wr_o, .flags_o, .branch_o, .branch_addr_o,
    .claimed_o, .unpredictable_o);

// *** tb/mmd_decode_bench.sv ***
/*
 * directed bench for the multiply and move decoder.
 * assumes a combinational register file answering the read indices.
 */
`timescale 1ns/10ps
module mmd_decode_bench;
    reg mclk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg instr_valid_i = 1'b0;
    reg [31:0] instr_i = 32'h0;
    reg is_32bit_i = 1'b0;
    reg cond_pass_i = 1'b0;
    reg in_cond_block_i = 1'b0;
    reg last_in_block_i = 1'b0;
    // carry and overflow set so kept flags are visible
    reg [3:0] flags_i = 4'h3;
    reg [31:0] r [0:15];
    wire [3:0] rd_idx_a_o, rd_idx_b_o, rd_idx_c_o, wr_idx_o, flags_o;
    wire wr_en_o, flags_wr_o, branch_o, claimed_o, unpredictable_o;
    wire [31:0] wr_data_o, branch_addr_o;
    wire [31:0] rd_data_a_i = r[rd_idx_a_o];
    wire [31:0] rd_data_b_i = r[rd_idx_b_o];
    wire [31:0] rd_data_c_i = r[rd_idx_c_o];
    integer num_errors = 0;
    integer checked = 0;
    integer k;
    always #4 mclk_i = ~mclk_i;
    mmd_decode dut (.mclk_i, .rst_n_i, .instr_valid_i, .instr_i, .is_32bit_i, .cond_pass_i, .in_cond_block_i,
        .last_in_block_i, .rd_idx_a_o, .rd_idx_b_o, .rd_idx_c_o, .rd_data_a_i, .rd_data_b_i, .rd_data_c_i,
        .flags_i, .wr_en_o, .wr_idx_o, .wr_data_o, .flags_wr_o, .flags_o, .branch_o, .branch_addr_o,
        .claimed_o, .unpredictable_o);
    task chk(input [63:0] n, input [31:0] e, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e)
            begin
                num_errors = num_errors + 1;
                $display("Error %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // m packs is_32bit, cond_pass, in_cond_block, last_in_block
    task run(input [31:0] i, input [3:0] m, input ew, input [3:0] ei, input [31:0] ed, input ef, input [3:0] eg,
        input eb, input eu);
        begin
            @(posedge mclk_i);
            instr_i <= i;
            {is_32bit_i, cond_pass_i, in_cond_block_i, last_in_block_i} <= m;
            instr_valid_i <= 1'b1;
            @(posedge mclk_i);
            instr_valid_i <= 1'b0;
            #1;
            chk("wr_en", {31'h0, ew}, {31'h0, wr_en_o});
            if (ew)
                chk("wr_idx", {28'h0, ei}, {28'h0, wr_idx_o});
            if (ew)
                chk("wr_data", ed, wr_data_o);
            chk("flags_wr", {31'h0, ef}, {31'h0, flags_wr_o});
            if (ef)
                chk("flags", {28'h0, eg}, {28'h0, flags_o});
            chk("branch", {31'h0, eb}, {31'h0, branch_o});
            if (eb)
                chk("br_addr", ed, branch_addr_o);
            chk("unpred", {31'h0, eu}, {31'h0, unpredictable_o});
            chk("claimed", {31'h0, ew | ef | eb | ~m[2]}, {31'h0, claimed_o});
        end
    endtask
    task results;
        begin
            if (num_errors == 0 && checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial
    begin
        for (k = 0; k < 16; k = k + 1)
            r[k] = {8{k[3:0]}};
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("rst_out", 32'h0, {28'h0, wr_en_o, flags_wr_o, branch_o, claimed_o});
        run(32'hfb024103, 4'hc, 1, 4'h1, r[2] * r[3] + r[4], 0, 4'h0, 0, 0);
        run(32'hfb026513, 4'hc, 1, 4'h5, r[6] - r[2] * r[3], 0, 4'h0, 0, 0);
        run(32'hfb026d13, 4'hc, 1, 4'hd, r[6] - r[2] * r[3], 0, 4'h0, 0, 1);
        run(32'h00002380, 4'h4, 1, 4'h3, 32'h80, 1, 4'h3, 0, 0);
        run(32'h00002000, 4'h6, 1, 4'h0, 32'h0, 0, 4'h0, 0, 0);
        run(32'h00002000, 4'h0, 0, 4'h0, 32'h0, 0, 4'h0, 0, 0);
        run(32'hf05f32ff, 4'hc, 1, 4'h2, 32'hffffffff, 1, 4'hb, 0, 0);
        run(32'hf05f4280, 4'hc, 1, 4'h2, 32'h40000000, 1, 4'h1, 0, 0);
        run(32'hf04f3dff, 4'hc, 1, 4'hd, 32'hffffffff, 0, 4'h0, 0, 1);
        run(32'hf64a37cd, 4'hc, 1, 4'h7, 32'h0000abcd, 0, 4'h0, 0, 0);
        run(32'hf6ca37cd, 4'hc, 1, 4'h7, 32'habcd7777, 0, 4'h0, 0, 0);
        run(32'hf6ca3fcd, 4'hc, 1, 4'hf, 32'habcdffff, 0, 4'h0, 0, 1);
        run(32'h00004692, 4'h4, 1, 4'ha, r[2], 0, 4'h0, 0, 0);
        run(32'h0000469f, 4'h4, 0, 4'h0, r[3], 0, 4'h0, 1, 0);
        run(32'h0000469f, 4'h7, 0, 4'h0, r[3], 0, 4'h0, 1, 0);
        run(32'h0000469f, 4'h6, 0, 4'h0, r[3], 0, 4'h0, 1, 1);
        run(32'h00000001, 4'h4, 1, 4'h1, 32'h0, 1, 4'h7, 0, 0);
        run(32'h00000001, 4'h6, 1, 4'h1, 32'h0, 1, 4'h7, 0, 1);
        run(32'hea4f0409, 4'hc, 1, 4'h4, r[9], 0, 4'h0, 0, 0);
        run(32'hea5f0409, 4'hc, 1, 4'h4, r[9], 1, 4'hb, 0, 0);
        run(32'hea4f0d0d, 4'hc, 1, 4'hd, r[13], 0, 4'h0, 0, 1);
        run(32'hea5f0d09, 4'hc, 1, 4'hd, r[9], 1, 4'hb, 0, 1);
        run(32'hea4f0449, 4'hc, 0, 4'h0, 32'h0, 0, 4'h0, 0, 0);
        results;
    end
endmodule
